// ==== design/fac_defines.vh ====
/*
 Constants for the flash command host: command bytes, autoselect offsets,
 protection codes and strobe timing. Assumes a 50 MHz host clock.
*/
`ifndef FAC_DEFINES_VH
`define FAC_DEFINES_VH
// ==========================================================
// Command bytes and unlock addresses
`define FAC_UNLOCK1_ADDR 19'h00555
`define FAC_UNLOCK2_ADDR 19'h002AA
`define FAC_UNLOCK1_DATA 8'hAA
`define FAC_UNLOCK2_DATA 8'h55
`define FAC_CMD_AUTOSEL 8'h90
`define FAC_CMD_PROGRAM 8'hA0
`define FAC_CMD_ERASE_SETUP 8'h80
`define FAC_CMD_SECT_ERASE 8'h30
`define FAC_CMD_CHIP_ERASE 8'h10
`define FAC_CMD_RESET 8'hF0
// ==========================================================
// Autoselect read offsets and protection answers
`define FAC_AS_MANUF 8'h00
`define FAC_AS_DEVICE 8'h01
`define FAC_AS_PROTECT 8'h02
`define FAC_AS_CONT 8'h03
`define FAC_PROT_YES 8'h01
`define FAC_PROT_NO 8'h00
// ==========================================================
// Command codes of the user port
`define FAC_OP_READ 3'h0
`define FAC_OP_AUTOSEL 3'h1
`define FAC_OP_PROGRAM 3'h2
`define FAC_OP_SECT_ERASE 3'h3
`define FAC_OP_CHIP_ERASE 3'h4
`define FAC_OP_RESET 3'h5
`define FAC_OP_ID_READ 3'h6
// ==========================================================
// Timing: glitch filter width in ns, strobe phase length in ns
`define FAC_GLITCH_NS 5
`define FAC_PHASE_NS 60
`define FAC_CLK_NS 20
`define FAC_PHASE_CYC ((`FAC_PHASE_NS + `FAC_CLK_NS - 1) / `FAC_CLK_NS)
`endif

// ==== design/fac_host.v ====
/*
 Host controller that drives an asynchronous parallel flash through its
 strobes: unlock sequences, program, erase, autoselect, reset and reads.
 Assumes the flash pins are wired directly and the device is a separate
 chip; the ready/busy pin arrives asynchronously and is synchronised.
*/
`timescale 1ns/1ps
`include "fac_defines.vh"

module fac_host #(
   parameter AW = 19,
   parameter PHASE = `FAC_PHASE_CYC
) (
   // Clock and reset
   input wire I_CLK,
   input wire I_RST_N,
   // User command port
   input wire I_REQ,
   input wire [2:0] I_OP,
   input wire [AW-1:0] I_ADDR,
   input wire [7:0] I_WDATA,
   input wire I_ID_HV,
   output reg O_BUSY,
   output reg O_DONE,
   output reg [7:0] O_RDATA,
   output reg O_ID_HV_REQ,
   output reg O_RESET_HV_REQ,
   // Flash pins
   output reg [AW-1:0] O_A,
   output reg [7:0] O_DQ_O,
   output reg O_DQ_OE,
   input wire [7:0] I_DQ,
   output reg O_CE_N,
   output reg O_OE_N,
   output reg O_WE_N,
   input wire I_READY_BUSY_N
);
   localparam S_IDLE = 5'b00001;
   localparam S_WSET = 5'b00010;
   localparam S_WLOW = 5'b00100;
   localparam S_WHOLD = 5'b01000;
   localparam S_READ = 5'b10000;

   reg [4:0] state_reg;
   reg [2:0] op_reg;
   reg [AW-1:0] addr_reg;
   reg [7:0] data_reg;
   reg [2:0] step_reg;
   reg [2:0] nsteps_reg;
   reg [7:0] cnt_reg;
   reg rb_meta_reg;
   reg rb_sync_reg;

   // Address and data of one bus cycle of the current command sequence
   // Bytes come from named constants, kept apart from logic
   function [AW+7:0] seq_word;
      input [2:0] op;
      input [2:0] step;
      input [AW-1:0] a;
      input [7:0] d;
      begin
         seq_word = {`FAC_UNLOCK1_ADDR, `FAC_CMD_RESET};
         case (step)
            3'h0: begin
               // Reset is one cycle with no unlock
               if (op == `FAC_OP_RESET)
                  seq_word = {`FAC_UNLOCK1_ADDR, `FAC_CMD_RESET};
               else
                  seq_word = {`FAC_UNLOCK1_ADDR, `FAC_UNLOCK1_DATA};
            end
            3'h1: seq_word = {`FAC_UNLOCK2_ADDR, `FAC_UNLOCK2_DATA};
            3'h2: begin
               case (op)
                  `FAC_OP_AUTOSEL:
                     seq_word = {`FAC_UNLOCK1_ADDR, `FAC_CMD_AUTOSEL};
                  `FAC_OP_PROGRAM:
                     seq_word = {`FAC_UNLOCK1_ADDR, `FAC_CMD_PROGRAM};
                  default:
                     seq_word = {`FAC_UNLOCK1_ADDR, `FAC_CMD_ERASE_SETUP};
               endcase
            end
            3'h3: begin
               if (op == `FAC_OP_PROGRAM)
                  seq_word = {a, d};
               else
                  seq_word = {`FAC_UNLOCK1_ADDR, `FAC_UNLOCK1_DATA};
            end
            3'h4: seq_word = {`FAC_UNLOCK2_ADDR, `FAC_UNLOCK2_DATA};
            3'h5: begin
               if (op == `FAC_OP_SECT_ERASE)
                  seq_word = {a, `FAC_CMD_SECT_ERASE};
               else
                  seq_word = {`FAC_UNLOCK1_ADDR, `FAC_CMD_CHIP_ERASE};
            end
            // A stray step writes reset, device back to read
            default: seq_word = {`FAC_UNLOCK1_ADDR, `FAC_CMD_RESET};
         endcase
      end
   endfunction

   // Number of write cycles in each sequence; full unlock first in every sequence except reset
   function [2:0] seq_len;
      input [2:0] op;
      begin
         case (op)
            `FAC_OP_AUTOSEL: seq_len = 3'h3;
            `FAC_OP_PROGRAM: seq_len = 3'h4;
            `FAC_OP_SECT_ERASE: seq_len = 3'h6;
            `FAC_OP_CHIP_ERASE: seq_len = 3'h6;
            default: seq_len = 3'h1;
         endcase
      end
   endfunction

   // Ready/busy is asynchronous, two flops before use
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         rb_meta_reg <= 1'b0;
         rb_sync_reg <= 1'b0;
      end else begin
         rb_meta_reg <= I_READY_BUSY_N;
         rb_sync_reg <= rb_meta_reg;
      end
   end

   // Main sequencer; WE low lasts PHASE cycles, the hold after it PHASE+1
   // Pulses stay far wider than the device noise filter
   always @(posedge I_CLK) begin
      if (!I_RST_N) begin
         state_reg <= S_IDLE;
         op_reg <= 3'h0;
         addr_reg <= {AW{1'b0}};
         data_reg <= 8'h00;
         step_reg <= 3'h0;
         nsteps_reg <= 3'h0;
         cnt_reg <= 8'h00;
         O_BUSY <= 1'b0;
         O_DONE <= 1'b0;
         O_RDATA <= 8'h00;
         O_ID_HV_REQ <= 1'b0;
         O_RESET_HV_REQ <= 1'b0;
         O_A <= {AW{1'b0}};
         O_DQ_O <= 8'h00;
         O_DQ_OE <= 1'b0;
         O_CE_N <= 1'b1;
         O_OE_N <= 1'b1;
         O_WE_N <= 1'b1; // WE high from reset
      end else begin
         O_DONE <= 1'b0;
         case (state_reg)
            S_IDLE: begin
               if (I_REQ) begin
                  op_reg <= I_OP;
                  addr_reg <= I_ADDR;
                  data_reg <= I_WDATA;
                  step_reg <= 3'h0;
                  nsteps_reg <= seq_len(I_OP);
                  cnt_reg <= 8'h00;
                  O_BUSY <= 1'b1;
                  if (I_OP == `FAC_OP_READ || I_OP == `FAC_OP_ID_READ) begin
                     // Read: array, status or ID.
                     state_reg <= S_READ;
                     O_A <= I_ADDR;
                     O_CE_N <= 1'b0;
                     O_OE_N <= 1'b0;
                     // Elevated A9 and A6 low for programmer ID.
                     O_ID_HV_REQ <= (I_OP == `FAC_OP_ID_READ) & I_ID_HV;
                     if ((I_OP == `FAC_OP_ID_READ) & I_ID_HV)
                        O_A[6] <= 1'b0;
                  end else begin
                     state_reg <= S_WSET;
                  end
               end
            end
            S_WSET: begin
               // Address, data and CE low set together, one cycle before WE falls
               {O_A, O_DQ_O} <= seq_word(op_reg, step_reg, addr_reg,
                                         data_reg);
               O_DQ_OE <= 1'b1;
               O_OE_N <= 1'b1; // OE high needed to write
               O_CE_N <= 1'b0;
               cnt_reg <= 8'h00;
               state_reg <= S_WLOW;
            end
            S_WLOW: begin
               O_WE_N <= 1'b0;
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == PHASE[7:0]) begin
                  // WE rises first; data held past it.
                  O_WE_N <= 1'b1;
                  cnt_reg <= 8'h00;
                  state_reg <= S_WHOLD;
               end
            end
            S_WHOLD: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == PHASE[7:0]) begin
                  O_CE_N <= 1'b1;
                  O_DQ_OE <= 1'b0;
                  cnt_reg <= 8'h00;
                  if (step_reg + 3'h1 == nsteps_reg) begin
                     // Algorithm ends on its own; wait for ready.
                     // A protected target just ends unchanged
                     if (rb_sync_reg) begin
                        state_reg <= S_IDLE;
                        O_BUSY <= 1'b0;
                        O_DONE <= 1'b1;
                     end
                  end else begin
                     step_reg <= step_reg + 3'h1;
                     state_reg <= S_WSET;
                  end
               end
            end
            S_READ: begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == PHASE[7:0] + PHASE[7:0]) begin
                  // Byte is ID, protect code or status as device chooses
                  O_RDATA <= I_DQ;
                  O_CE_N <= 1'b1;
                  O_OE_N <= 1'b1;
                  O_ID_HV_REQ <= 1'b0;
                  O_BUSY <= 1'b0;
                  O_DONE <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            default: begin
               state_reg <= S_IDLE;
               O_BUSY <= 1'b0;
            end
         endcase
         // Temporary unprotect is left to the board; held low.
         if (state_reg == S_IDLE && I_REQ)
            O_RESET_HV_REQ <= 1'b0;
      end
   end
endmodule

// ==== verification/fac_flash_model.sv ====
/*
 Behavioural flash: command decode, ID codes, byte array, ready/busy.
 Assumes one host and a board that lifts A9 when i_vid_a9 is high.
*/
`timescale 1ns/1ps
`include "fac_defines.vh"
// ==========================================================
// Flash model
module fac_flash_model #(
   parameter AW = 19,
   parameter [31:0] IDS = 32'h4E002D1C // Codes arbitrary
) (
   // Flash pins
   input wire [AW-1:0] i_a,
   input wire [7:0] i_dq,
   input wire i_ce_n,
   input wire i_oe_n,
   input wire i_we_n,
   input wire i_vid_a9,
   output wire [7:0] o_dq,
   output reg o_ready_busy_n
);
   reg [7:0] mem [0:255];
   reg [AW-1:0] lat_a;
   reg [2:0] step;
   reg asel;
   reg ers;
   integer k;
   wire idm = asel || (i_vid_a9 && !i_a[6]);
   wire [7:0] rd = idm ? IDS[8*i_a[1:0] +: 8] : mem[i_a[7:0]];
   // Power-up: read array, all erased, all sectors open
   initial begin
      for (k = 0; k < 256; k = k + 1) mem[k] = 8'hFF;
      {step, asel, ers, o_ready_busy_n} = 6'h01;
   end
   // A released bus shows the inverse, never a stale byte
   assign o_dq = (!i_ce_n && !i_oe_n) ? rd : ~rd;
   // Address on the later falling edge; WE always falls inside CE
   always @(negedge i_we_n) if (!i_ce_n && i_oe_n) lat_a = i_a;
   // Data on the earlier rising edge; only full sequences act, but the reset byte acts at any step
   always @(posedge i_we_n) if (!i_ce_n && i_oe_n) begin
      if (i_dq == `FAC_CMD_RESET) {step, asel, ers} = 5'h00;
      else if (step == 0)
         step = (lat_a == `FAC_UNLOCK1_ADDR && i_dq == `FAC_UNLOCK1_DATA);
      else if (step == 1)
         step = (lat_a == `FAC_UNLOCK2_ADDR && i_dq == `FAC_UNLOCK2_DATA) ? 2 : 0;
      else if (step == 3) begin
         mem[lat_a[7:0]] = i_dq;
         step = 0;
         o_ready_busy_n <= 1'b0;
         o_ready_busy_n <= #400 1'b1;
      end else begin
         step = (i_dq == `FAC_CMD_PROGRAM && !ers) ? 3 : 0;
         asel = asel || i_dq == `FAC_CMD_AUTOSEL;
         if (ers && (i_dq == `FAC_CMD_SECT_ERASE || i_dq == `FAC_CMD_CHIP_ERASE)) begin
            for (k = 0; k < 256; k = k + 1) mem[k] = 8'hFF;
            o_ready_busy_n <= 1'b0;
            o_ready_busy_n <= #400 1'b1;
         end
         ers = i_dq == `FAC_CMD_ERASE_SETUP;
      end
   end
endmodule

// ==== verification/fac_host_sva.sv ====
/*
 Checker for fac_host strobes and user handshake.
 Assumes PHASE at its default of 3 cycles.
*/
`timescale 1ns/1ps
// ==========================================================
// Strobe and handshake checker
module fac_host_sva #(
   parameter AW = 19
) (
   // Clock, reset and user port
   input wire I_CLK,
   input wire I_RST_N,
   input wire I_REQ,
   input wire [2:0] I_OP,
   input wire O_BUSY,
   input wire O_DONE,
   // Flash pins
   input wire [AW-1:0] O_A,
   input wire [7:0] O_DQ_O,
   input wire O_DQ_OE,
   input wire O_CE_N,
   input wire O_OE_N,
   input wire O_WE_N
);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   // Write qualification and bus contention
   write_qualify_a: assert property (
      !O_WE_N |-> !O_CE_N && O_OE_N)
      else $error("write strobe without select");
   drive_clash_a: assert property (O_DQ_OE |-> O_OE_N)
      else $error("data driven while output enabled");
   // Long write pulse, far above the noise filter
   we_width_a: assert property (
      $fell(O_WE_N) |-> !O_WE_N[*3] ##[1:3] O_WE_N)
      else $error("write pulse width wrong");
   addr_hold_a: assert property (!O_WE_N |-> $stable(O_A))
      else $error("address moved under write strobe");
   data_hold_a: assert property (
      !O_WE_N |-> O_DQ_OE && $stable(O_DQ_O))
      else $error("data moved under write strobe");
   // User handshake
   done_pulse_a: assert property (O_DONE |=> !O_DONE)
      else $error("done longer than one cycle");
   take_cause_a: assert property ($rose(O_BUSY) |-> $past(I_REQ))
      else $error("busy without request");
   read_latency_a: assert property (
      $rose(O_BUSY) && I_OP == 3'h0 |-> ##[7:9] O_DONE)
      else $error("read latency wrong");
   idle_quiet_a: assert property (
      !O_BUSY |-> O_CE_N && O_WE_N && !O_DQ_OE)
      else $error("strobes active while idle");
endmodule

bind fac_host fac_host_sva #(.AW(AW)) u_sva (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
   .I_REQ(I_REQ), .I_OP(I_OP), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_A(O_A),
   .O_DQ_O(O_DQ_O), .O_DQ_OE(O_DQ_OE), .O_CE_N(O_CE_N), .O_OE_N(O_OE_N),
   .O_WE_N(O_WE_N));

// ==== verification/test_fac_host.sv ====
/*
 Self-checking bench for fac_host against the flash model.
 Assumes default PHASE and a 50 MHz clock.
*/
`timescale 1ns/1ps
// ==========================================================
// Bench top
module test_fac_host;
   localparam [31:0] IDS = 32'h4E002D1C; // Codes arbitrary
   reg I_CLK = 0, I_RST_N = 0, I_REQ = 0, I_ID_HV = 0;
   reg [2:0] I_OP = 0;
   reg [18:0] I_ADDR = 0, a;
   reg [7:0] I_WDATA = 0, d;
   wire O_BUSY, O_DONE, O_ID_HV_REQ, O_DQ_OE, O_CE_N, O_OE_N, O_WE_N, rb_n;
   wire O_RESET_HV_REQ;
   wire [7:0] O_RDATA, O_DQ_O, fl_dq;
   wire [18:0] O_A;
   integer fail_count = 0, total_checks = 0, n, k;
   reg [8:0] notes [$];
   reg [8:0] note;
   always #10 I_CLK = ~I_CLK;
   fac_host uut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REQ(I_REQ), .I_OP(I_OP),
      .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_ID_HV(I_ID_HV), .O_BUSY(O_BUSY),
      .O_DONE(O_DONE), .O_RDATA(O_RDATA), .O_ID_HV_REQ(O_ID_HV_REQ),
      .O_RESET_HV_REQ(O_RESET_HV_REQ), .O_A(O_A), .O_DQ_O(O_DQ_O),
      .O_DQ_OE(O_DQ_OE),
      .I_DQ(O_DQ_OE ? O_DQ_O : fl_dq), .O_CE_N(O_CE_N), .O_OE_N(O_OE_N),
      .O_WE_N(O_WE_N), .I_READY_BUSY_N(rb_n));
   fac_flash_model #(.IDS(IDS)) flash (.i_a(O_A), .i_dq(O_DQ_O), .i_ce_n(O_CE_N),
      .i_oe_n(O_OE_N), .i_we_n(O_WE_N), .i_vid_a9(O_ID_HV_REQ), .o_dq(fl_dq),
      .o_ready_busy_n(rb_n));
   task check(input string nm, input [7:0] seen, input [7:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // One request at a falling edge; note what a read must return
   task op(input [2:0] c, input [18:0] ad, input [7:0] wd, input hv,
           input chk, input [7:0] ex);
      {I_OP, I_ADDR, I_WDATA, I_ID_HV, I_REQ} = {c, ad, wd, hv, 1'b1};
      notes.push_back({chk, ex});
      @(negedge I_CLK);
      I_REQ = 0;
      for (n = 0; n < 3000 && O_DONE !== 1'b1; n = n + 1) @(negedge I_CLK);
      if (n == 3000) fail_count = fail_count + 1;
      @(negedge I_CLK);
   endtask
   // Result watcher takes the oldest note at each completion
   // Looks at the falling edge, where the outputs have settled
   always @(negedge I_CLK) if (O_DONE === 1'b1 && notes.size() > 0) begin
      note = notes.pop_front();
      check("O_RESET_HV_REQ", {7'h00, O_RESET_HV_REQ}, 8'h00);
      if (note[8])
         check("O_RDATA", O_RDATA, note[7:0]);
   end
   // Main sequence
   initial begin
      void'($urandom(48));
      repeat (20) @(negedge I_CLK);
      I_RST_N = 1;
      for (k = 0; k < 4; k = k + 1) begin
         a = $urandom;
         a[1:0] = k[1:0]; // Distinct bytes, so no stale program hits
         d = $urandom;
         op(0, a, 0, 0, 1, 8'hFF);
         op(2, a, d, 0, 0, 0);
         op(0, a, 0, 0, 1, d);
      end
      op(1, 0, 0, 0, 0, 0);
      for (k = 0; k < 4; k = k + 1)
         op(0, {a[18:2], k[1:0]}, 0, 0, 1, IDS[8*k +: 8]);
      op(5, 0, 0, 0, 0, 0);
      op(0, a, 0, 0, 1, d);
      for (k = 0; k < 4; k = k + 1)
         op(6, {a[18:7], 5'h00, k[1:0]}, 0, 1, 1, IDS[8*k +: 8]);
      op(3, a, 0, 0, 0, 0); // No unprotect cycle is ever sent
      op(0, a, 0, 0, 1, 8'hFF);
      op(2, a, d, 0, 0, 0);
      op(4, 0, 0, 0, 0, 0);
      op(0, a, 0, 0, 1, 8'hFF);
      test_done;
   end
   // Watchdog well beyond the expected several hundred cycles
   initial begin
      #1000000;
      fail_count = fail_count + 1;
      test_done;
   end
endmodule
